// ===== jsio_asserts.sv
/*
 * jsio_asserts: concurrent checks on the pins and bus of jsio_top.
 * assumes it is bound into jsio_top and sees only that module's ports.
 */
`timescale 1ns/1ps
module jsio_asserts #(
  parameter int NPIN = 4,
  parameter int MIN_LEVEL_CYC = 8,
  parameter int CONFIRM_CYC = 20
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic trig_pin,
  input wire logic [NPIN-1:0] io_in,
  input wire logic [NPIN-1:0] io_out,
  input wire logic [NPIN-1:0] io_oe,
  input wire logic trig_out,
  input wire logic ready,
  input wire logic valid
);
  // ---------------------------------------------------------------------
  // helper logic
  // ---------------------------------------------------------------------
  logic [NPIN-1:0] drv;
  logic [NPIN-1:0] in_q_r;
  logic [7:0] quiet_r;
  logic [7:0] trig_hi_r;
  logic [15:0] conf_hi_r;
  logic ctrl_wr_r;
  assign drv = io_out & io_oe;
  // cycles since any pin moved, and raw trigger-high length; saturating
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      in_q_r <= '0;
      quiet_r <= '0;
      trig_hi_r <= '0;
    end else begin
      in_q_r <= io_in;
      quiet_r <= (io_in != in_q_r) ? 8'h00 :
                 quiet_r + {7'h00, quiet_r != 8'hff};
      trig_hi_r <= trig_pin ? trig_hi_r + {7'h00, trig_hi_r != 8'hff} : 8'h00;
    end
  end
  // length of the present high stretch of the driven outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      conf_hi_r <= '0;
      ctrl_wr_r <= 1'b0;
    end else begin
      conf_hi_r <= (|drv) ? conf_hi_r + 16'h0001 : 16'h0000;
      ctrl_wr_r <= hsel && hready && htrans[1] && hwrite &&
                   haddr[7:0] == jsio_pkg::OFS_CTRL;
    end
  end
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence ctrl_wr_s;
    ctrl_wr_r;
  endsequence
  sequence conf_end_s;
    $fell(|drv) && !$past(ready);
  endsequence
  // ---------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus slave stalled or answered with an error");
  ready_first_a: assert property (
    $rose(hresetn) |=> ready && io_oe == '0)
    else $error("ready not high on the first cycle after reset");
  trig_pulse_a: assert property (trig_out |=> !trig_out)
    else $error("trigger output longer than one cycle");
  trig_settle_a: assert property (
    trig_out |-> trig_hi_r >= MIN_LEVEL_CYC)
    else $error("trigger accepted before the pin level settled");
  ready_cause_a: assert property (
    $fell(ready) |-> quiet_r < MIN_LEVEL_CYC + 8)
    else $error("ready dropped with no recent input change");
  conf_len_a: assert property (
    conf_end_s |-> conf_hi_r == CONFIRM_CYC)
    else $error("confirm pulse has the wrong length");
  conf_order_a: assert property (
    !ready && (|drv) |=> !(ready && (|drv)))
    else $error("ready rose while the confirm output was still high");
  valid_track_a: assert property (
    ctrl_wr_s |=> ##2 valid == $past(hwdata[jsio_pkg::CTRL_VALID], 3))
    else $error("valid output does not follow the control bit");
endmodule : jsio_asserts

bind jsio_top jsio_asserts #(.NPIN(NPIN), .MIN_LEVEL_CYC(MIN_LEVEL_CYC),
  .CONFIRM_CYC(CONFIRM_CYC)) u_chk (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .trig_pin(trig_pin), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
  .trig_out(trig_out), .ready(ready), .valid(valid));

// ===== jsio_pkg.sv
/*
 * jsio_pkg: register map, field positions, reset values and timing
 * counts of the job-select / handshake i/o block.
 * assumes a 100 MHz clock and a single-word ahb-lite slave per register.
 */
package jsio_pkg;
  // ---------------------------------------------------------------------
  // register offsets (byte addresses)
  // ---------------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_PINMAP = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_RESULT = 8'h0c;
  localparam logic [7:0] OFS_DONE = 8'h10;
  localparam logic [7:0] OFS_DIR = 8'h14;
  // ---------------------------------------------------------------------
  // control fields
  // ---------------------------------------------------------------------
  localparam int CTRL_TRIGMODE = 0;
  localparam int CTRL_CONFIRM = 1;
  localparam int CTRL_PERM = 2;
  localparam int CTRL_VALID = 3;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
  // done register fields: bit0 job done ok, bit1 job failed, bit2 teach done
  localparam int DONE_JOB_OK = 0;
  localparam int DONE_JOB_FAIL = 1;
  localparam int DONE_TEACH = 2;
  // pin function codes, four bits per configurable pin
  localparam logic [3:0] FN_NONE = 4'h0;
  localparam logic [3:0] FN_ENABLE = 4'h1;
  localparam logic [3:0] FN_JOBPULSE = 4'h2;
  localparam logic [3:0] FN_TEACH = 4'h3;
  localparam logic [3:0] FN_JOBTWO = 4'h4;
  localparam logic [3:0] FN_JOBBIT = 4'h8;  // 8..c: job bit 0..4
  localparam logic [3:0] FN_RESULT = 4'h1;  // output function: result
  localparam logic [3:0] FN_CONFIRM = 4'h2; // output function: confirm
  localparam logic [31:0] PINMAP_RESET = 32'h0000_0000;
  localparam logic [3:0] DIR_RESET = 4'h0;
  // ---------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int MIN_LEVEL_MS = 2;
  localparam int PULSE_GAP_MS = 50;
  localparam int CONFIRM_MS = 20;
  localparam int MIN_LEVEL_CYC = MIN_LEVEL_MS * 1000 * CLK_MHZ;
  localparam int PULSE_GAP_CYC = PULSE_GAP_MS * 1000 * CLK_MHZ;
  localparam int CONFIRM_CYC = CONFIRM_MS * 1000 * CLK_MHZ;
endpackage : jsio_pkg

// ===== jsio_plc.sv
/*
 * jsio_plc: behavioural process controller driving the function pins.
 * assumes the bench resolves pin levels against the device's enables.
 */
`timescale 1ns/1ps
module jsio_plc #(
  parameter int HOLD = 14
) (
  input wire logic hclk,
  input wire logic ready,
  output logic trig_pin,
  output logic [3:0] lvl
);
  initial begin
    trig_pin = 1'b0;
    lvl = 4'h0;
  end
  // all bits change together, then stay put long enough to qualify
  task automatic drive(input logic [3:0] v);
    @(posedge hclk);
    lvl <= v;
    repeat (HOLD) @(posedge hclk);
  endtask : drive
  // equal high and low halves, like the recommended 5ms/5ms shape
  task automatic pulse(input int idx, input int n);
    for (int k = 0; k < n; k++) begin
      drive(lvl | (4'h1 << idx));
      drive(lvl & ~(4'h1 << idx));
    end
  endtask : pulse
  // waits for ready unless a teach is pending; teach holds its pin high
  task automatic trig(input logic any);
    while (!any && ready !== 1'b1) @(posedge hclk);
    trig_pin <= 1'b1;
    repeat (HOLD + 6) @(posedge hclk);
    trig_pin <= 1'b0;
    repeat (HOLD) @(posedge hclk);
  endtask : trig
endmodule : jsio_plc

// ===== jsio_top.sv
/*
 * jsio_top: process-control digital i/o of a vision sensor: trigger
 * gating, job select (binary, two-job, pulse count), teach request,
 * ready / valid / confirm / result outputs, ahb-lite register slave.
 * assumes pins are asynchronous to hclk; the image engine is software
 * that reads the request from status and writes the done register.
 */
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
// What this block does
// - hardware trigger accepted only on the dedicated trigger pin
// - binary mode decodes up to five pins as job number, pin with function code 8 lsb
// - binary change taken in idle; one made while busy waits for idle; ready drops on change
// - two-job mode: high selects job 2, low selects job 1
// - two-job change taken in idle; one made while busy waits for idle; ready low until switch done
// - pulse mode accepts pulses only while ready; first pulse drops it
// - pulses counted until 50ms gap, then job switch; ready stays low
// - with confirm option, confirm pulse precedes ready rising again
// - confirm high 20ms on successful change; stays low on failure
// - teach rising edge followed by trigger starts teaching
// - teach kind (temporary or permanent) latched from the control perm bit and shown in status
// - teach only while ready; ready low until teaching completes
// - ready high only when idle, though triggers pass in every state but teaching; valid high when outputs valid
// - each result output carries a detector result or expression value
// - job select and teach work only in triggered mode
// - each shared pin set individually as input or output, one function
`timescale 1ns/1ps
module jsio_top #(
  parameter int NPIN = 4,
  parameter int MIN_LEVEL_CYC = jsio_pkg::MIN_LEVEL_CYC,
  parameter int PULSE_GAP_CYC = jsio_pkg::PULSE_GAP_CYC,
  parameter int CONFIRM_CYC = jsio_pkg::CONFIRM_CYC
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic trig_pin,
  input wire logic [NPIN-1:0] io_in,
  output logic [NPIN-1:0] io_out,
  output logic [NPIN-1:0] io_oe,
  output logic trig_out,
  output logic ready,
  output logic valid
);
  localparam int CW = 32;
  typedef enum logic [2:0] {
    JS_IDLE, JS_BIN, JS_PULSE, JS_WAIT, JS_CONF, JS_TEACH_ARM, JS_TEACH
  } jsio_state_t;

  // -----------------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------------
  // function code of pin i out of the packed map
  function automatic logic [3:0] jsio_fn(input logic [31:0] map,
                                         input int i);
    jsio_fn = map[i*4 +: 4];
  endfunction : jsio_fn

  // -----------------------------------------------------------------------
  // input synchronisers and level filter
  // -----------------------------------------------------------------------
  logic [NPIN:0] s1_r, s2_r, s3_r, lvl_r;
  logic [CW-1:0] stab_r [NPIN+1];
  // three stages; second and third must agree before a change counts
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= {trig_pin, io_in};
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  // a level is taken only after it stood the minimum length
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lvl_r <= '0;
      for (int i = 0; i <= NPIN; i++) stab_r[i] <= '0;
    end else begin
      for (int i = 0; i <= NPIN; i++) begin
        if (s2_r[i] != s3_r[i] || s3_r[i] == lvl_r[i]) begin
          stab_r[i] <= '0;
        end else if (stab_r[i] >= CW'(MIN_LEVEL_CYC - 1)) begin
          lvl_r[i] <= s3_r[i];
          stab_r[i] <= '0;
        end else begin
          stab_r[i] <= stab_r[i] + 1'b1;
        end
      end
    end
  end

  // -----------------------------------------------------------------------
  // registers
  // -----------------------------------------------------------------------
  logic [31:0] ctrl_r, pinmap_r, result_r;
  logic [NPIN-1:0] dir_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;
  logic done_job_ok, done_job_fail, done_teach;
  logic trigmode;
  assign trigmode = ctrl_r[jsio_pkg::CTRL_TRIGMODE];

  // decode per-pin functions from the filtered levels
  logic en_lvl, pulse_lvl, teach_lvl, two_lvl, two_used, bin_used;
  logic [4:0] bin_lvl;
  always_comb begin
    en_lvl = 1'b1;
    pulse_lvl = 1'b0;
    teach_lvl = 1'b0;
    two_lvl = 1'b0;
    two_used = 1'b0;
    bin_used = 1'b0;
    bin_lvl = '0;
    for (int i = 0; i < NPIN; i++) begin
      if (!dir_r[i]) begin
        case (jsio_fn(pinmap_r, i))
          jsio_pkg::FN_ENABLE: en_lvl = lvl_r[i];
          jsio_pkg::FN_JOBPULSE: pulse_lvl = lvl_r[i];
          jsio_pkg::FN_TEACH: teach_lvl = lvl_r[i];
          jsio_pkg::FN_JOBTWO: begin
            two_lvl = lvl_r[i];
            two_used = 1'b1;
          end
          default: begin
            if (jsio_fn(pinmap_r, i) >= jsio_pkg::FN_JOBBIT &&
                jsio_fn(pinmap_r, i) <= 4'hc) begin
              bin_lvl[3'(jsio_fn(pinmap_r, i) - jsio_pkg::FN_JOBBIT)] =
                lvl_r[i];
              bin_used = 1'b1;
            end
          end
        endcase
      end
    end
  end

  // -----------------------------------------------------------------------
  // job select / teach state machine
  // -----------------------------------------------------------------------
  jsio_state_t st_r;
  logic [4:0] bin_prev_r, job_r, cnt_r;
  logic two_prev_r, pulse_prev_r, teach_prev_r, trig_prev_r, perm_r;
  logic [CW-1:0] tmr_r;
  logic trig_rise, trig_ok;
  assign trig_rise = lvl_r[NPIN] & ~trig_prev_r;
  // only the dedicated trigger pin triggers, gated by the enable level
  assign trig_ok = trig_rise & en_lvl;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= JS_IDLE;
      bin_prev_r <= '0;
      job_r <= '0;
      cnt_r <= '0;
      two_prev_r <= 1'b0;
      pulse_prev_r <= 1'b0;
      teach_prev_r <= 1'b0;
      trig_prev_r <= 1'b0;
      perm_r <= 1'b0;
      tmr_r <= '0;
      ready <= 1'b0;
      trig_out <= 1'b0;
    end else begin
      trig_prev_r <= lvl_r[NPIN];
      pulse_prev_r <= pulse_lvl;
      teach_prev_r <= teach_lvl;
      trig_out <= trig_ok && st_r != JS_TEACH;
      case (st_r)
        JS_IDLE: begin
          ready <= 1'b1;
          bin_prev_r <= bin_lvl;
          two_prev_r <= two_lvl;
          // ignored outside triggered mode; while busy teach and pulse starts are lost, binary and two-job changes wait
          if (trigmode) begin
            if (bin_used && bin_lvl != bin_prev_r) begin
              ready <= 1'b0;
              st_r <= JS_BIN;
              tmr_r <= '0;
            end else if (two_used && two_lvl != two_prev_r) begin
              ready <= 1'b0;
              job_r <= two_lvl ? 5'd1 : 5'd0;
              st_r <= JS_WAIT;
            end else if (pulse_lvl && !pulse_prev_r) begin
              ready <= 1'b0;
              cnt_r <= 5'd1;
              tmr_r <= '0;
              st_r <= JS_PULSE;
            end else if (teach_lvl && !teach_prev_r) begin
              ready <= 1'b0;
              perm_r <= ctrl_r[jsio_pkg::CTRL_PERM];
              st_r <= JS_TEACH_ARM;
            end
          end
        end
        JS_BIN: begin
          // bits may settle one by one; take the pattern once it held
          bin_prev_r <= bin_lvl;
          if (bin_lvl != bin_prev_r) tmr_r <= '0;
          else if (tmr_r >= CW'(MIN_LEVEL_CYC)) begin
            job_r <= bin_lvl;
            st_r <= JS_WAIT;
          end else tmr_r <= tmr_r + 1'b1;
        end
        JS_PULSE: begin
          if (pulse_lvl && !pulse_prev_r) begin
            cnt_r <= cnt_r + 1'b1;
            tmr_r <= '0;
          end else if (pulse_lvl) tmr_r <= '0;
          else if (tmr_r >= CW'(PULSE_GAP_CYC - 1)) begin
            job_r <= cnt_r - 1'b1;
            st_r <= JS_WAIT;
          end else tmr_r <= tmr_r + 1'b1;
        end
        JS_WAIT: begin
          // ready stays low until software reports the switch
          tmr_r <= '0;
          if (done_job_ok) begin
            st_r <= ctrl_r[jsio_pkg::CTRL_CONFIRM] ? JS_CONF : JS_IDLE;
          end else if (done_job_fail) begin
            st_r <= JS_IDLE;
          end
        end
        JS_CONF: begin
          // confirm first, ready only afterwards
          if (tmr_r >= CW'(CONFIRM_CYC - 1)) st_r <= JS_IDLE;
          else tmr_r <= tmr_r + 1'b1;
        end
        JS_TEACH_ARM: begin
          if (trig_ok) st_r <= JS_TEACH;
        end
        JS_TEACH: begin
          if (done_teach) st_r <= JS_IDLE;
        end
        default: st_r <= JS_IDLE;
      endcase
    end
  end

  // -----------------------------------------------------------------------
  // output pins
  // -----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      io_out <= '0;
      io_oe <= '0;
      valid <= 1'b0;
    end else begin
      valid <= ctrl_r[jsio_pkg::CTRL_VALID];
      for (int i = 0; i < NPIN; i++) begin
        io_oe[i] <= dir_r[i];
        case (jsio_fn(pinmap_r, i))
          jsio_pkg::FN_RESULT: io_out[i] <= dir_r[i] & result_r[i];
          jsio_pkg::FN_CONFIRM:
            io_out[i] <= dir_r[i] & (st_r == JS_CONF);
          default: io_out[i] <= 1'b0;
        endcase
      end
    end
  end

  // -----------------------------------------------------------------------
  // ahb-lite slave: zero wait states, always okay
  // -----------------------------------------------------------------------
  logic [31:0] status_w;
  // exactly 32 bits so nothing is padded behind our back
  assign status_w = {21'h00_0000, perm_r, st_r == JS_TEACH,
                     st_r == JS_WAIT, job_r, 1'b0, lvl_r[NPIN], ready};
  assign done_job_ok = wr_pend_r && wr_addr_r == jsio_pkg::OFS_DONE &&
                       hwdata[jsio_pkg::DONE_JOB_OK];
  assign done_job_fail = wr_pend_r && wr_addr_r == jsio_pkg::OFS_DONE &&
                         hwdata[jsio_pkg::DONE_JOB_FAIL];
  assign done_teach = wr_pend_r && wr_addr_r == jsio_pkg::OFS_DONE &&
                      hwdata[jsio_pkg::DONE_TEACH];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= '0;
      ctrl_r <= jsio_pkg::CTRL_RESET;
      pinmap_r <= jsio_pkg::PINMAP_RESET;
      result_r <= '0;
      dir_r <= NPIN'(jsio_pkg::DIR_RESET);
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) wr_addr_r <= haddr[7:0];
      if (wr_pend_r) begin
        case (wr_addr_r)
          jsio_pkg::OFS_CTRL: ctrl_r <= hwdata;
          jsio_pkg::OFS_PINMAP: pinmap_r <= hwdata;
          jsio_pkg::OFS_RESULT: result_r <= hwdata;
          jsio_pkg::OFS_DIR: dir_r <= hwdata[NPIN-1:0];
          default: ;
        endcase
      end
      // read data registered so it stands in the data phase
      if (hsel && hready && htrans[1] && !hwrite) begin
        case (haddr[7:0])
          jsio_pkg::OFS_CTRL: hrdata <= ctrl_r;
          jsio_pkg::OFS_PINMAP: hrdata <= pinmap_r;
          jsio_pkg::OFS_STATUS: hrdata <= status_w;
          jsio_pkg::OFS_RESULT: hrdata <= result_r;
          jsio_pkg::OFS_DIR: hrdata <= 32'(dir_r);
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule : jsio_top

// ===== testbench.sv
/*
 * testbench: bus-driven scenarios for jsio_top with a controller model.
 * assumes shortened timing parameters and a zero-wait ahb-lite slave.
 */
`timescale 1ns/1ps
module testbench;
  localparam int MIN = 8;
  localparam int CONF = 20;
  localparam int GAP = 40;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, q;
  logic hreadyout, hresp, trig_pin, trig_out, ready, valid;
  logic [3:0] io_in, io_out, io_oe, lvl;
  int n_fail = 0;
  int n_checks = 0;
  int n_trig = 0;
  always #5 hclk = ~hclk;
  // wire level: the device wins where it drives, else the controller
  assign io_in = (io_oe & io_out) | (~io_oe & lvl);
  always @(posedge hclk) if (trig_out === 1'b1) n_trig <= n_trig + 1;
  jsio_top #(.NPIN(4), .MIN_LEVEL_CYC(MIN), .PULSE_GAP_CYC(GAP),
    .CONFIRM_CYC(CONF)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .trig_pin(trig_pin),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe), .trig_out(trig_out),
    .ready(ready), .valid(valid));
  jsio_plc #(.HOLD(MIN + 6)) plc (.hclk(hclk), .ready(ready),
    .trig_pin(trig_pin), .lvl(lvl));
  // ---------------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------------
  task automatic end_of_test;
    if (n_fail == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // one single transfer; read data is taken at the data-phase edge
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    hsize <= 3'b010;
    haddr <= {24'h00_0000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : ahb
  task automatic wait_rdy(input logic v);
    for (int k = 0; k < 400 && ready !== v; k++) @(posedge hclk);
    chk("ready", {31'h0, ready}, {31'h0, v});
  endtask : wait_rdy
  // finish a job change and measure the confirm pulse before ready
  task automatic done_conf(input logic [31:0] d, input int e);
    int c;
    c = 0;
    ahb(1'b1, jsio_pkg::OFS_DONE, d);
    for (int k = 0; k < 200 && ready !== 1'b1; k++) begin
      @(posedge hclk);
      if (io_out[3] === 1'b1) c++;
    end
    chk("confirm cycles", c, e);
    wait_rdy(1'b1);
  endtask : done_conf
  // ---------------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------------
  initial begin
    repeat (20000) @(posedge hclk);
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, jsio_pkg::OFS_CTRL, 0);
    chk("ctrl reset", q, jsio_pkg::CTRL_RESET);
    ahb(1'b0, jsio_pkg::OFS_PINMAP, 0);
    chk("pinmap reset", q, jsio_pkg::PINMAP_RESET);
    ahb(1'b1, 8'h40, 32'hffff_ffff);
    ahb(1'b0, 8'h40, 0);
    chk("unmapped", q, 32'h0000_0000);
    // binary job number, first pin is the lsb
    ahb(1'b1, jsio_pkg::OFS_PINMAP, 32'h0000_0098);
    plc.drive(4'b0011);
    chk("ready binary", {31'h0, ready}, 32'h0);
    // the pattern must hold the settle time before the job is taken
    repeat (2 * MIN) @(posedge hclk);
    ahb(1'b0, jsio_pkg::OFS_STATUS, 0);
    chk("status binary", q, 32'h0000_0118);
    ahb(1'b1, jsio_pkg::OFS_DONE, 32'h0000_0001);
    wait_rdy(1'b1);
    ahb(1'b1, jsio_pkg::OFS_PINMAP, 0);
    plc.drive(4'b0000);
    // two-job pin with confirm output on pin 3, success then failure
    ahb(1'b1, jsio_pkg::OFS_CTRL, 32'h0000_000b);
    // control lands at the data-phase edge, valid one edge later
    repeat (2) @(posedge hclk);
    chk("valid", {31'h0, valid}, 32'h1);
    ahb(1'b1, jsio_pkg::OFS_DIR, 32'h0000_0008);
    ahb(1'b1, jsio_pkg::OFS_PINMAP, 32'h0000_2400);
    plc.drive(4'b0100);
    ahb(1'b0, jsio_pkg::OFS_STATUS, 0);
    chk("status two high", q, 32'h0000_0108);
    done_conf(32'h0000_0001, CONF);
    plc.drive(4'b0000);
    ahb(1'b0, jsio_pkg::OFS_STATUS, 0);
    chk("status two low", q, 32'h0000_0100);
    done_conf(32'h0000_0002, 0);
    // three pulses select the third job once the gap has passed
    ahb(1'b1, jsio_pkg::OFS_PINMAP, 32'h0000_2002);
    plc.pulse(0, 3);
    chk("ready pulse", {31'h0, ready}, 32'h0);
    repeat (60) @(posedge hclk);
    ahb(1'b0, jsio_pkg::OFS_STATUS, 0);
    chk("status pulse", q, 32'h0000_0110);
    done_conf(32'h0000_0001, CONF);
    // trigger gated by the enable pin, then teach on pin 2
    ahb(1'b1, jsio_pkg::OFS_PINMAP, 32'h0000_0310);
    plc.trig(1'b0);
    chk("trig blocked", n_trig, 0);
    plc.drive(4'b0010);
    plc.trig(1'b0);
    chk("trig passed", n_trig, 1);
    plc.drive(4'b0110);
    chk("ready teach", {31'h0, ready}, 32'h0);
    plc.trig(1'b1);
    ahb(1'b0, jsio_pkg::OFS_STATUS, 0);
    chk("teaching", q[10:8], 3'b010);
    ahb(1'b1, jsio_pkg::OFS_DONE, 32'h0000_0004);
    wait_rdy(1'b1);
    // without triggered mode a job pin change is ignored
    ahb(1'b1, jsio_pkg::OFS_CTRL, 0);
    ahb(1'b1, jsio_pkg::OFS_PINMAP, 32'h0000_0008);
    plc.drive(4'b0001);
    chk("ready untrig", {31'h0, ready}, 32'h1);
    // result outputs on pins 2 and 3 follow their register bits
    ahb(1'b1, jsio_pkg::OFS_DIR, 32'h0000_000c);
    ahb(1'b1, jsio_pkg::OFS_PINMAP, 32'h0000_1100);
    for (int k = 0; k < 2; k++) begin
      ahb(1'b1, jsio_pkg::OFS_RESULT, 32'h0000_0004 << k);
      // pins follow the register one edge after the write lands
      repeat (2) @(posedge hclk);
      chk("pins driven", {24'h00_0000, io_oe, io_out},
          32'h0000_00c0 | (32'h0000_0004 << k));
    end
    end_of_test();
  end
endmodule : testbench
